// ===== ssc_subrange_select.sv
/*
 * Subrange select counter: buttons, host load, decode, AFC reset pulse, readback.
 * Assumes host strobe and data arrive asynchronously; bus pin resolved outside.
 */
`timescale 1ns/1ns
module ssc_subrange_select (
	// Clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      nrst_i,
	// Front panel
	input  wire logic                      button_step_line_a_i,
	input  wire logic                      button_step_line_b_i,
	// Mode inputs
	input  wire logic                      remote_button_lock_i,
	input  wire logic                      autorange_indicator_blank_i,
	// Host load
	input  wire logic [3:0]                host_load_data_i,
	input  wire logic                      host_load_strobe_i,
	// Host readback
	input  wire logic                      host_read_i,
	output logic [ssc_pkg::BUS_W-1:0]      host_bus_driver_o,
	output logic                           host_bus_driver_oe_o,
	// Loop lock and measurement
	input  wire logic                      loop_locked_i,
	input  wire logic                      measure_start_i,
	output logic                           frequency_control_loop_reset_o,
	output logic                           unlocked_lamp_o,
	// Indicators and range switching
	output logic [ssc_pkg::NUM_CODES-1:0]  indicator_led_board_o,
	output logic                           manual_ranging_led_o,
	output logic [ssc_pkg::NUM_CODES-1:0]  range_control_board_o,
	output logic [3:0]                     subrange_counter_o
);
	ssc_step_if step_bus ();

	logic [3:0] subrange_counter_q;
	logic [3:0] subrange_counter_d;
	logic [4:0] ld_meta_q;
	logic [4:0] ld_sync_q;
	logic       ld_prev_q;
	logic [2:0] ctl_meta_q;
	logic [2:0] ctl_sync_q;
	logic       meas_prev_q;
	logic [ssc_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
	logic [ssc_pkg::NUM_CODES-1:0]   onehot;
	logic       host_load;
	logic [1:0] rd_meta_q;
	ssc_pkg::ssc_step_t step;

	function automatic logic [ssc_pkg::NUM_CODES-1:0] decode(input logic [3:0] v);
		decode = '0;
		decode[v] = 1'b1;
	endfunction

	ssc_button_edge u_button_edge (
		.core_clk_i           (core_clk_i),
		.nrst_i               (nrst_i),
		.button_step_line_a_i (button_step_line_a_i),
		.button_step_line_b_i (button_step_line_b_i),
		.step                 (step_bus.src)
	);

	// Host strobe and data synchroniser
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ld_meta_q <= 5'h00;
			ld_sync_q <= 5'h00;
			ld_prev_q <= 1'b0;
		end else begin
			ld_meta_q <= {host_load_strobe_i, host_load_data_i};
			ld_sync_q <= ld_meta_q;
			ld_prev_q <= ld_sync_q[4];
		end
	end

	// Remote lock, loop lock, measurement and read synchronisers
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_meta_q  <= 3'h0;
			ctl_sync_q  <= 3'h0;
			meas_prev_q <= 1'b0;
			rd_meta_q   <= 2'h0;
		end else begin
			ctl_meta_q  <= {measure_start_i, loop_locked_i, remote_button_lock_i};
			ctl_sync_q  <= ctl_meta_q;
			meas_prev_q <= ctl_sync_q[2];
			rd_meta_q   <= {rd_meta_q[0], host_read_i};
		end
	end

	assign host_load = ld_sync_q[4] & ~ld_prev_q;

	// Step selection, buttons locked under remote control
	always_comb begin
		step = ssc_pkg::SSC_STEP_NONE;
		if (!ctl_sync_q[0]) begin
			if (step_bus.inc_pulse && !step_bus.dec_pulse)
				step = ssc_pkg::SSC_STEP_UP;
			else if (step_bus.dec_pulse && !step_bus.inc_pulse)
				step = ssc_pkg::SSC_STEP_DOWN;
		end
	end

	always_comb begin
		subrange_counter_d = subrange_counter_q;
		if (host_load)
			subrange_counter_d = ld_sync_q[3:0];
		else begin
			case (step)
				ssc_pkg::SSC_STEP_UP:   subrange_counter_d = subrange_counter_q + 4'h1;
				ssc_pkg::SSC_STEP_DOWN: subrange_counter_d = subrange_counter_q - 4'h1;
				default:                subrange_counter_d = subrange_counter_q;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			subrange_counter_q <= ssc_pkg::CNT_RESET;
		else
			subrange_counter_q <= subrange_counter_d;
	end

	// Loop reset pulse on each measurement start
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			pulse_cnt_q <= '0;
		else if (ctl_sync_q[2] && !meas_prev_q)
			pulse_cnt_q <= ssc_pkg::AFC_PULSE_CYC[ssc_pkg::PULSE_CNT_W-1:0];
		else if (pulse_cnt_q != '0)
			pulse_cnt_q <= pulse_cnt_q - 1'b1;
	end

	// Outputs
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			frequency_control_loop_reset_o <= 1'b0;
			unlocked_lamp_o                <= 1'b0;
			indicator_led_board_o          <= '0;
			manual_ranging_led_o           <= 1'b0;
			range_control_board_o          <= '0;
			subrange_counter_o             <= ssc_pkg::CNT_RESET;
			host_bus_driver_o              <= '0;
			host_bus_driver_oe_o           <= 1'b0;
		end else begin
			frequency_control_loop_reset_o <= (pulse_cnt_q != '0);
			unlocked_lamp_o                <= ~ctl_sync_q[1];
			indicator_led_board_o          <= autorange_indicator_blank_i ? '0 : onehot;
			manual_ranging_led_o           <= ~autorange_indicator_blank_i;
			range_control_board_o          <= onehot;
			subrange_counter_o             <= subrange_counter_q;
			host_bus_driver_o              <= {ctl_sync_q[1], ssc_pkg::PLUGIN_ID, subrange_counter_q};
			host_bus_driver_oe_o           <= rd_meta_q[1];
		end
	end

	assign onehot = decode(subrange_counter_q);

	property p_load_wins;
		@(posedge core_clk_i) disable iff (!nrst_i)
		host_load |=> subrange_counter_q == $past(ld_sync_q[3:0]);
	endproperty
	a_load_wins: assert property (p_load_wins) else $error("host load lost");
	property p_remote_lock;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(ctl_sync_q[0] && !host_load) |=> $stable(subrange_counter_q);
	endproperty
	a_remote_lock: assert property (p_remote_lock) else $error("button acted in remote");
	property p_step_up;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(step == ssc_pkg::SSC_STEP_UP && !host_load) |=> subrange_counter_q == $past(subrange_counter_q) + 4'h1;
	endproperty
	a_step_up: assert property (p_step_up) else $error("up step wrong");
	property p_step_dn;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(step == ssc_pkg::SSC_STEP_DOWN && !host_load) |=> subrange_counter_q == $past(subrange_counter_q) - 4'h1;
	endproperty
	a_step_dn: assert property (p_step_dn) else $error("down step wrong");
	property p_hold;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(!host_load && step == ssc_pkg::SSC_STEP_NONE) |=> $stable(subrange_counter_q);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without cause");
	property p_blank;
		@(posedge core_clk_i) disable iff (!nrst_i)
		autorange_indicator_blank_i |=> indicator_led_board_o == '0;
	endproperty
	a_blank: assert property (p_blank) else $error("leds lit in autorange");
	property p_manual_one;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!autorange_indicator_blank_i |=> $onehot(indicator_led_board_o) && manual_ranging_led_o;
	endproperty
	a_manual_one: assert property (p_manual_one) else $error("manual leds wrong");
	property p_decode;
		@(posedge core_clk_i) disable iff (!nrst_i)
		1'b1 |=> range_control_board_o == (16'h0001 << $past(subrange_counter_q));
	endproperty
	a_decode: assert property (p_decode) else $error("decode wrong");
	property p_afc_pulse;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(ctl_sync_q[2] && !meas_prev_q) |=> ##1 frequency_control_loop_reset_o;
	endproperty
	a_afc_pulse: assert property (p_afc_pulse) else $error("no loop reset");
	property p_afc_len;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$rose(frequency_control_loop_reset_o) |-> pulse_cnt_q == ssc_pkg::AFC_PULSE_CYC - 1;
	endproperty
	a_afc_len: assert property (p_afc_len) else $error("loop reset length wrong");
	property p_readback;
		@(posedge core_clk_i) disable iff (!nrst_i)
		host_bus_driver_oe_o |-> host_bus_driver_o[3:0] == $past(subrange_counter_q);
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");
	property p_lock;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(ctl_sync_q[1]) |-> !unlocked_lamp_o;
	endproperty
	a_lock: assert property (p_lock) else $error("lamp on while locked");
	property p_unlock;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!ctl_sync_q[1] |=> unlocked_lamp_o;
	endproperty
	a_unlock: assert property (p_unlock) else $error("lamp off while unlocked");
endmodule

// ===== ssc_pkg.sv
/*
 * Constants and types for the subrange select counter.
 * Assumes one 10 MHz clock and an active-low asynchronous reset.
 */
package ssc_pkg;
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned AFC_PULSE_NS   = 1000;
	localparam int unsigned AFC_PULSE_CYC  = (AFC_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0]  CNT_RESET      = 4'h0;
	localparam logic [3:0]  PLUGIN_ID      = 4'hA; // Arbitrary identification value
	localparam int unsigned CNT_W          = 4;
	localparam int unsigned BUS_W          = 9;
	localparam int unsigned NUM_CODES      = 16;
	localparam int unsigned PULSE_CNT_W    = 8;

	typedef enum logic [1:0] {
		SSC_STEP_NONE,
		SSC_STEP_UP,
		SSC_STEP_DOWN
	} ssc_step_t;
endpackage

// ===== ssc_step_if.sv
/*
 * Carrier between the counter and its button front end.
 * Assumes both ends share core_clk_i.
 */
`timescale 1ns/1ns
interface ssc_step_if;
	logic inc_pulse;
	logic dec_pulse;
	modport src (output inc_pulse, output dec_pulse);
	modport dst (input  inc_pulse, input  dec_pulse);
endinterface

// ===== ssc_button_edge.sv
/*
 * Button synchroniser and press detector.
 * Assumes raw button lines asynchronous to core_clk_i, active high when pressed.
 */
`timescale 1ns/1ns
module ssc_button_edge (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	// Raw buttons
	input  wire logic button_step_line_a_i,
	input  wire logic button_step_line_b_i,
	// Step pulses out
	ssc_step_if.src   step
);
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;

	// Two-stage synchroniser then previous-value register
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
			prev_q <= 2'h0;
		end else begin
			meta_q <= {button_step_line_b_i, button_step_line_a_i};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign step.inc_pulse = sync_q[0] & ~prev_q[0];
	assign step.dec_pulse = sync_q[1] & ~prev_q[1];

	property p_one_pulse;
		@(posedge core_clk_i) disable iff (!nrst_i)
		step.inc_pulse |=> !step.inc_pulse;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("press gave more than one step");
endmodule

// ===== ssc_host_model.sv
/*
 * Host processor model: parallel load of the subrange and bus readback.
 * Assumes its tasks are called at a falling edge of core_clk_i.
 */
`timescale 1ns/1ns
module ssc_host_model #(
	parameter logic [3:0] SKIP_LO = 4'hE,
	parameter logic [3:0] SKIP_HI = 4'hF
) (
	// Clock
	input  wire logic       core_clk_i,
	// Bus from device
	input  wire logic [8:0] bus_i,
	input  wire logic       bus_oe_i,
	// Host lines
	output logic      [3:0] data_o,
	output logic            strobe_o,
	output logic            read_o
);
	initial begin
		data_o = 4'h0;
		strobe_o = 1'b0;
		read_o = 1'b0;
	end
	// Unused codes replaced by code zero
	task automatic load(input logic [3:0] v);
		data_o = (v == SKIP_LO || v == SKIP_HI) ? 4'h0 : v;
		repeat (3) @(negedge core_clk_i);
		strobe_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
		strobe_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask
	// Released bus reads as a toggling pattern
	task automatic rd(output logic [8:0] v);
		read_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
		v = bus_oe_i ? bus_i : 9'h155;
		read_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask
endmodule

// ===== testbench.sv
/*
 * Self-checking bench for the subrange select counter.
 * Assumes the host model drives the load and read lines.
 */
`timescale 1ns/1ns
module testbench;
	logic        core_clk_i, nrst_i, btn_a, btn_b, lock, auto, locked, meas;
	logic [3:0]  hdata, cnt;
	logic        hstb, hrd, oe, afc, unl, man;
	logic [8:0]  bus, rv;
	logic [15:0] led, rng;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          k;
	ssc_subrange_select dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .button_step_line_a_i(btn_a),
		.button_step_line_b_i(btn_b), .remote_button_lock_i(lock), .autorange_indicator_blank_i(auto),
		.host_load_data_i(hdata), .host_load_strobe_i(hstb), .host_read_i(hrd), .host_bus_driver_o(bus),
		.host_bus_driver_oe_o(oe), .loop_locked_i(locked), .measure_start_i(meas),
		.frequency_control_loop_reset_o(afc), .unlocked_lamp_o(unl), .indicator_led_board_o(led),
		.manual_ranging_led_o(man), .range_control_board_o(rng), .subrange_counter_o(cnt));
	ssc_host_model host (.core_clk_i(core_clk_i), .bus_i(bus), .bus_oe_i(oe), .data_o(hdata),
		.strobe_o(hstb), .read_o(hrd));
	always #50 core_clk_i = ~core_clk_i;
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic press(input logic dn);
		if (dn)
			btn_b = 1'b1;
		else
			btn_a = 1'b1;
		repeat (10) @(negedge core_clk_i);
		btn_a = 1'b0;
		btn_b = 1'b0;
		repeat (6) @(negedge core_clk_i);
	endtask
	task automatic ld(input logic [3:0] v);
		host.load(v);
		chk("count", {12'h0, v}, {12'h0, cnt});
		chk("leds", 16'h1 << v, led);
		chk("range", 16'h1 << v, rng);
		chk("manual", 16'h1, {15'h0, man});
		chk("unlocked", {15'h0, ~locked}, {15'h0, unl});
		host.rd(rv);
		chk("bus", {7'h0, locked, ssc_pkg::PLUGIN_ID, v}, {7'h0, rv});
	endtask
	initial begin
		core_clk_i = 1'b0;
		nrst_i = 1'b0;
		{btn_a, btn_b, lock, auto, locked, meas} = 6'h00;
		repeat (10) @(negedge core_clk_i);
		nrst_i = 1'b1;
		chk("reset count", 16'h0, {12'h0, cnt});
		for (k = 0; k < 14; k++) begin
			locked = k[0];
			ld(k[3:0]);
		end
		ld(4'h5);
		press(1'b0);
		chk("up", 16'h6, {12'h0, cnt});
		press(1'b1);
		chk("down", 16'h5, {12'h0, cnt});
		lock = 1'b1;
		press(1'b0);
		chk("locked", 16'h5, {12'h0, cnt});
		lock = 1'b0;
		auto = 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk("auto leds", 16'h0, led);
		chk("auto manual", 16'h0, {15'h0, man});
		chk("auto range", 16'h0020, rng);
		auto = 1'b0;
		fork
			host.load(4'h9);
			begin
				repeat (3) @(negedge core_clk_i);
				press(1'b0);
			end
		join
		chk("load wins", 16'h9, {12'h0, cnt});
		meas = 1'b1;
		k = 0;
		repeat (30) begin
			@(negedge core_clk_i);
			if (afc === 1'b1)
				k++;
		end
		chk("afc width", 16'd10, k[15:0]);
		meas = 1'b0;
		nrst_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		chk("rst count", 16'h0, {12'h0, cnt});
		chk("rst range", 16'h0, rng);
		nrst_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk("rst leds", 16'h1, led);
		press(1'b1);
		chk("down wrap", 16'hF, {12'h0, cnt});
		finish_test();
	end
	initial begin
		#500000;
		n_mismatch++;
		finish_test();
	end
endmodule
